/* File: core/dac_ctl.sv */
// control logic of a quad 10-bit dac: serial frame, load mask, resets, reference
// assumes sclk from the host stands still between frames, pins asynchronous
`timescale 1ns/10ps

module dac_ctl (
    // system clock domain
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // serial link from the host
    input wire logic sclk,
    input wire logic sdin,
    input wire logic sync_n,
    // control pins
    input wire logic load_strobe_n,
    input wire logic hw_reset_n,
    input wire logic reset_level_select,
    // converter side
    output dac_ctl_pkg::codes_t dac_code_q,
    output logic ref_off_q,
    output logic [3:0] mask_q
);

    // link domain state
    logic [4:0] bit_cnt_q; // bits taken in this frame
    logic [22:0] shift_q; // bits before the last one
    dac_ctl_pkg::frame_t word_q; // last complete frame
    logic frame_tgl_q; // flips once per complete frame

    // system domain state
    dac_ctl_pkg::pins_t raw; // unsynchronised inputs
    dac_ctl_pkg::pins_t meta_q; // first synchroniser stage
    dac_ctl_pkg::pins_t sync_q; // second stage, safe to read
    logic strobe_d_q; // previous strobe level, for edge
    logic tgl_ack_q; // last frame toggle consumed
    dac_ctl_pkg::init_state_t state_q;
    dac_ctl_pkg::codes_t input_q; // input (staging) registers

    // decode
    logic pend; // a finished frame waits
    logic take; // frame consumed this cycle
    logic act; // frame acted on this cycle
    logic strobe_fall; // accepted strobe falling edge
    logic hw_on; // hardware reset released
    logic [9:0] clear_code; // code chosen by the select pin
    logic [9:0] frame_code;

    // bit counter restarts whenever sync is high, also without sclk
    // a cut frame never reaches the capture count, so it is dropped
    always_ff @(negedge sclk or negedge reset_n or posedge sync_n) begin
        if (!reset_n) begin
            bit_cnt_q <= 5'h00;
        end else if (sync_n) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != dac_ctl_pkg::FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01; // extra bits past 24 are dropped
        end
    end

    // shift msb first on the falling serial edge
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 23'h000000;
        end else if (!sync_n && bit_cnt_q < dac_ctl_pkg::LAST_BIT) begin
            shift_q <= {shift_q[21:0], sdin};
        end
    end

    // capture the whole word on its 24th bit; it then stays still
    // until the next frame, which makes the word safe to read across
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= '0;
            frame_tgl_q <= 1'b0;
        end else if (!sync_n && bit_cnt_q == dac_ctl_pkg::LAST_BIT) begin
            word_q <= {shift_q, sdin};
            frame_tgl_q <= ~frame_tgl_q;
        end
    end

    // gather pins and the frame toggle for synchronisation
    always_comb begin
        raw.sync_n = sync_n;
        raw.load_strobe_n = load_strobe_n;
        raw.hw_reset_n = hw_reset_n;
        raw.reset_level_select = reset_level_select;
        raw.frame_tgl = frame_tgl_q;
    end

    // two-stage synchroniser; nothing else reads meta_q
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // hardware reset reads as held until the pin is seen, so the
            // power-on phase cannot end on the flops' own reset value
            meta_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            sync_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else if (clk_en) begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    // decode of the frame and strobe
    always_comb begin
        hw_on = sync_q.hw_reset_n;
        clear_code = sync_q.reset_level_select ? dac_ctl_pkg::CODE_MID
                                               : dac_ctl_pkg::CODE_ZERO;
        frame_code = word_q.data[15:dac_ctl_pkg::CODE_LSB];
        pend = sync_q.frame_tgl != tgl_ack_q;
        // act only once sync is back high
        take = clk_en && pend && sync_q.sync_n;
        act = take && state_q == dac_ctl_pkg::ST_RUN;
        // strobe edges are dropped during power-on
        strobe_fall = clk_en && state_q == dac_ctl_pkg::ST_RUN
                      && strobe_d_q && !sync_q.load_strobe_n;
    end

    // frame consumption; frames arriving before init are discarded
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tgl_ack_q <= 1'b0;
        end else if (take) begin
            tgl_ack_q <= sync_q.frame_tgl;
        end
    end

    // power-on phase ends only once hardware reset is high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dac_ctl_pkg::ST_POR;
        end else if (clk_en && hw_on) begin
            state_q <= dac_ctl_pkg::ST_RUN;
        end
    end

    // strobe level history for falling edge detection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_d_q <= 1'b1;
        end else if (clk_en) begin
            strobe_d_q <= sync_q.load_strobe_n;
        end
    end

    // mask register; address nibble is ignored
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= dac_ctl_pkg::MASK_RST;
        end else if (act && word_q.cmd == dac_ctl_pkg::CMD_SW_RESET) begin
            mask_q <= dac_ctl_pkg::MASK_RST;
        end else if (act && word_q.cmd == dac_ctl_pkg::CMD_MASK) begin
            mask_q <= word_q.data[3:0];
        end
    end

    // reference control, on by default; only data bit 0 counts
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_off_q <= dac_ctl_pkg::REF_OFF_RST;
        end else if (act && word_q.cmd == dac_ctl_pkg::CMD_SW_RESET) begin
            ref_off_q <= dac_ctl_pkg::REF_OFF_RST;
        end else if (act && word_q.cmd == dac_ctl_pkg::CMD_REF_SETUP) begin
            ref_off_q <= word_q.data[dac_ctl_pkg::REF_BIT];
        end
    end

    // per channel input and dac registers
    generate
        for (genvar ch = 0; ch < dac_ctl_pkg::N_CH; ch++) begin : g_ch
            logic sel; // channel addressed by the frame
            assign sel = word_q.addr[ch];

            // input register: cleared with the outputs so a later
            // strobe cannot bring back a stale pre-reset value
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    input_q[ch] <= dac_ctl_pkg::CODE_ZERO;
                end else if (!clk_en) begin
                    input_q[ch] <= input_q[ch]; // frozen
                end else if (state_q == dac_ctl_pkg::ST_POR || !hw_on) begin
                    input_q[ch] <= clear_code;
                end else if (act && word_q.cmd == dac_ctl_pkg::CMD_SW_RESET) begin
                    input_q[ch] <= clear_code;
                end else if (act && sel && (word_q.cmd == dac_ctl_pkg::CMD_WRITE_IN
                             || word_q.cmd == dac_ctl_pkg::CMD_WRITE_UPD)) begin
                    input_q[ch] <= frame_code;
                end
            end

            // dac register: a software reset or a frame command for this channel wins over a strobe edge
            // arriving in the same cycle; the edge is then lost
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    dac_code_q[ch] <= dac_ctl_pkg::CODE_ZERO;
                end else if (!clk_en) begin
                    dac_code_q[ch] <= dac_code_q[ch]; // frozen
                end else if (state_q == dac_ctl_pkg::ST_POR) begin
                    dac_code_q[ch] <= clear_code;
                end else if (!hw_on) begin
                    dac_code_q[ch] <= clear_code;
                end else if (act && word_q.cmd == dac_ctl_pkg::CMD_SW_RESET) begin
                    dac_code_q[ch] <= clear_code;
                end else if (act && sel && word_q.cmd == dac_ctl_pkg::CMD_UPDATE) begin
                    dac_code_q[ch] <= input_q[ch];
                end else if (act && sel && word_q.cmd == dac_ctl_pkg::CMD_WRITE_UPD) begin
                    dac_code_q[ch] <= frame_code;
                end else if (act && sel && word_q.cmd == dac_ctl_pkg::CMD_WRITE_IN
                             && !sync_q.load_strobe_n) begin
                    // strobe held low: immediate update, mask ignored
                    dac_code_q[ch] <= frame_code;
                end else if (strobe_fall && !mask_q[ch]) begin
                    dac_code_q[ch] <= input_q[ch];
                end
                // otherwise held at its value
            end
        end
    endgenerate

    // checks, all in the system clock domain; link-side timing is left
    // to the bench, since a second clock here would need its own
    // clocking and disable
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_strobe_loads;
        strobe_fall && hw_on && !act && !mask_q[0]
            |=> dac_code_q[0] == $past(input_q[0]);
    endproperty
    a_strobe_loads: assert property (p_strobe_loads)
        else $error("unmasked channel missed strobe update");

    property p_mask_blocks;
        strobe_fall && hw_on && !take && mask_q[1] |=> $stable(dac_code_q[1]);
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked channel followed strobe");

    property p_hw_clear;
        clk_en && !hw_on |=> dac_code_q[2] == $past(clear_code)
            && input_q[2] == $past(clear_code);
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("hardware reset did not clear channel");

    property p_hold_quiet;
        clk_en && hw_on && state_q == dac_ctl_pkg::ST_RUN && !take && !strobe_fall
            |=> $stable(dac_code_q);
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("output changed without write or strobe");

    property p_sw_reset;
        act && word_q.cmd == dac_ctl_pkg::CMD_SW_RESET && hw_on
            |=> mask_q == dac_ctl_pkg::MASK_RST && !ref_off_q
            && dac_code_q[3] == $past(clear_code);
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset left state behind");

    // each power-on cycle loads the level the select pin shows then
    property p_por_level;
        clk_en && state_q == dac_ctl_pkg::ST_POR
            |=> dac_code_q[0] == $past(clear_code) && $stable(mask_q);
    endproperty
    a_por_level: assert property (p_por_level)
        else $error("power-on level wrong");

    property p_init_waits;
        state_q == dac_ctl_pkg::ST_POR && !hw_on |=> state_q == dac_ctl_pkg::ST_POR;
    endproperty
    a_init_waits: assert property (p_init_waits)
        else $error("init finished under hardware reset");

    property p_ref_setup;
        act && word_q.cmd == dac_ctl_pkg::CMD_REF_SETUP
            |=> ref_off_q == $past(word_q.data[0]);
    endproperty
    a_ref_setup: assert property (p_ref_setup)
        else $error("reference bit not taken");

    property p_mask_load;
        act && word_q.cmd == dac_ctl_pkg::CMD_MASK |=> mask_q == $past(word_q.data[3:0]);
    endproperty
    a_mask_load: assert property (p_mask_load)
        else $error("mask not loaded");

    property p_act_after_sync;
        take |-> sync_q.sync_n && $past(pend);
    endproperty
    a_act_after_sync: assert property (p_act_after_sync)
        else $error("frame taken while sync low");

    // channel 1 is one of the two masked ones in use, so this also shows the mask is ignored
    property p_low_strobe_write;
        act && word_q.cmd == dac_ctl_pkg::CMD_WRITE_IN && word_q.addr[1]
            && !sync_q.load_strobe_n && hw_on
            |=> dac_code_q[1] == $past(frame_code);
    endproperty
    a_low_strobe_write: assert property (p_low_strobe_write)
        else $error("write with strobe low did not update");

    // a write with update is one valid write that moves a channel
    // off the level it has held since power-on or a clear
    property p_write_update;
        act && word_q.cmd == dac_ctl_pkg::CMD_WRITE_UPD && word_q.addr[0] && hw_on
            |=> dac_code_q[0] == $past(frame_code);
    endproperty
    a_write_update: assert property (p_write_update)
        else $error("write and update did not reach channel");

    // the update command copies the staged code even on a masked
    // channel: the mask only blocks the pin, not the serial path
    property p_soft_update;
        act && word_q.cmd == dac_ctl_pkg::CMD_UPDATE && word_q.addr[3] && hw_on
            |=> dac_code_q[3] == $past(input_q[3]);
    endproperty
    a_soft_update: assert property (p_soft_update)
        else $error("update command missed channel");

endmodule : dac_ctl

/* File: core/dac_ctl_pkg.sv */
// shared constants and types for the quad dac control block
// assumes a 125 MHz system clock and a 24-bit serial frame
package dac_ctl_pkg;
    // channel and code geometry
    localparam int unsigned N_CH = 4;
    localparam int unsigned CODE_W = 10;
    localparam int unsigned CNT_W = 5;
    // frame bit counting, in serial clock edges
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] LAST_BIT = 5'h17;
    // command codes, top nibble of the frame
    localparam logic [3:0] CMD_WRITE_IN = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0] CMD_MASK = 4'h5;
    localparam logic [3:0] CMD_SW_RESET = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP = 4'h7;
    // field positions inside the 16 data bits
    localparam int unsigned CODE_LSB = 6;
    localparam int unsigned REF_BIT = 0;
    // clear codes and reset values
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_MID = 10'h200;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic REF_OFF_RST = 1'b0;
    // least hardware reset pulse, kept by the host
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned HW_RESET_MIN_NS = 30;
    localparam int unsigned HW_RESET_MIN_CYC =
        (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // received frame
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [15:0] data;
    } frame_t;
    // pins and link flags that cross into the system clock
    typedef struct packed {
        logic sync_n;
        logic load_strobe_n;
        logic hw_reset_n;
        logic reset_level_select;
        logic frame_tgl;
    } pins_t;
    // power-on phase
    typedef enum logic [0:0] {
        ST_POR = 1'b0,
        ST_RUN = 1'b1
    } init_state_t;
    typedef logic [N_CH-1:0][CODE_W-1:0] codes_t;
endpackage : dac_ctl_pkg

/* File: tb/dac_host.sv */
// host side model: shifts serial frames into the quad dac control block
// assumes the block samples sdin on falling sclk while sync_n is low
`timescale 1ns/10ps
module dac_host (
    // serial link toward the block
    output logic sclk,
    output logic sdin,
    output logic sync_n
);
    // link clock rests low between frames, never free running
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        sync_n = 1'b1;
    end
    // shift nbits of a frame msb first at a 64 ns link period
    task automatic send(input dac_ctl_pkg::frame_t f, input int nbits);
        sync_n = 1'b0;
        // odd offset keeps sclk edges off the system clock edges
        #35;
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b1;
            sdin = f[23-i];
            #32;
            sclk = 1'b0;
            #32;
        end
        sync_n = 1'b1;
        // released data line shows the inverse, never a stale value
        sdin = ~sdin;
        // long idle gap so both sync edges cross into the system clock
        #400;
    endtask : send
endmodule : dac_host

/* File: tb/dac_ctl_tb.sv */
// self-checking bench for the quad dac control block
// assumes the host model drives the link; pins change on falling ref_clk
`timescale 1ns/10ps
module dac_ctl_tb;
    // clock, reset and control pins
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic hw_reset_n = 1'b0;
    logic reset_level_select = 1'b1;
    // serial link from the host model
    logic sclk;
    logic sdin;
    logic sync_n;
    // block outputs and expectations
    dac_ctl_pkg::codes_t dac_code_q;
    logic ref_off_q;
    logic [3:0] mask_q;
    dac_ctl_pkg::codes_t exp;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    // 125 MHz system clock
    always #4 ref_clk = ~ref_clk;

    dac_host i_dac_host (.sclk(sclk), .sdin(sdin), .sync_n(sync_n));

    // clk_en tied high: freezing is not part of the documented behaviour
    dac_ctl i_dac_ctl (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
        .sclk(sclk), .sdin(sdin), .sync_n(sync_n),
        .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
        .reset_level_select(reset_level_select),
        .dac_code_q(dac_code_q), .ref_off_q(ref_off_q), .mask_q(mask_q)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // compare all four dac codes
    task automatic check_codes(input dac_ctl_pkg::codes_t e);
        comparisons++;
        if (dac_code_q !== e) begin
            mismatches++;
            $display("mismatch at %0t: codes %h expected %h", $time, dac_code_q, e);
        end
    endtask : check_codes

    // compare a small flag vector
    task automatic check_vec(input logic [3:0] got, input logic [3:0] e);
        comparisons++;
        if (got !== e) begin
            mismatches++;
            $display("mismatch at %0t: flags %h expected %h", $time, got, e);
        end
    endtask : check_vec

    // data frame, low six bits filled with junk the block must ignore
    function automatic dac_ctl_pkg::frame_t mk(input logic [3:0] c, input logic [3:0] a,
                                               input logic [9:0] code);
        return {c, a, code, 6'h15};
    endfunction : mk

    task automatic send(input dac_ctl_pkg::frame_t f);
        i_dac_host.send(f, 24);
        cyc(2);
    endtask : send

    // hardware reset held low through power up, select high
    task automatic t_power_up;
        cyc(10);
        // a strobe pulse while power-on holds must not move anything
        load_strobe_n = 1'b0;
        cyc(4);
        load_strobe_n = 1'b1;
        cyc(4);
        exp = {4{10'h200}};
        check_codes(exp);
        check_vec(mask_q, 4'h0);
        check_vec({3'h0, ref_off_q}, 4'h0);
        send(mk(dac_ctl_pkg::CMD_WRITE_UPD, 4'hf, 10'h3ff));
        check_codes(exp);
        hw_reset_n = 1'b1;
        cyc(10);
        check_codes(exp);
    endtask : t_power_up

    // reference bit with junk in address and upper data bits
    task automatic t_reference;
        send({dac_ctl_pkg::CMD_REF_SETUP, 4'hf, 16'hfffe});
        check_vec({3'h0, ref_off_q}, 4'h0);
        send({dac_ctl_pkg::CMD_REF_SETUP, 4'h0, 16'h0001});
        check_vec({3'h0, ref_off_q}, 4'h1);
    endtask : t_reference

    // mask channels 1 and 3, then pulse and hold the strobe
    task automatic t_mask_strobe;
        send({dac_ctl_pkg::CMD_MASK, 4'hf, 16'h000a});
        check_vec(mask_q, 4'ha);
        send(mk(dac_ctl_pkg::CMD_WRITE_IN, 4'hf, 10'h155));
        check_codes(exp);
        load_strobe_n = 1'b0;
        cyc(6);
        exp[0] = 10'h155;
        exp[2] = 10'h155;
        check_codes(exp);
        // strobe stays low: writes go straight through, mask or not
        send(mk(dac_ctl_pkg::CMD_WRITE_IN, 4'h2, 10'h0aa));
        exp[1] = 10'h0aa;
        check_codes(exp);
        load_strobe_n = 1'b1;
        cyc(6);
        // software update of a masked channel still works
        send(mk(dac_ctl_pkg::CMD_UPDATE, 4'h8, 10'h000));
        exp[3] = 10'h155;
        check_codes(exp);
        // a frame cut short at 20 bits must do nothing
        i_dac_host.send(mk(dac_ctl_pkg::CMD_WRITE_UPD, 4'hf, 10'h001), 20);
        cyc(2);
        check_codes(exp);
    endtask : t_mask_strobe

    // software reset with select low clears codes, mask and reference bit
    task automatic t_soft_reset;
        reset_level_select = 1'b0;
        cyc(6);
        send({dac_ctl_pkg::CMD_SW_RESET, 4'h0, 16'h0000});
        exp = '0;
        check_codes(exp);
        check_vec(mask_q, 4'h0);
        check_vec({3'h0, ref_off_q}, 4'h0);
    endtask : t_soft_reset

    // minimum hardware reset pulse in mid run
    task automatic t_hw_reset;
        send(mk(dac_ctl_pkg::CMD_WRITE_UPD, 4'hf, 10'h2aa));
        exp = {4{10'h2aa}};
        check_codes(exp);
        hw_reset_n = 1'b0;
        cyc(dac_ctl_pkg::HW_RESET_MIN_CYC);
        hw_reset_n = 1'b1;
        cyc(8);
        exp = '0;
        check_codes(exp);
    endtask : t_hw_reset

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        cyc(6);
        reset_n = 1'b1;
        t_power_up;
        t_reference;
        t_mask_strobe;
        t_soft_reset;
        t_hw_reset;
        close_out;
    end

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            close_out;
        end
    end
endmodule : dac_ctl_tb
